// [logic/sfc_pkg.sv]
// Constants, types and decode helpers for the serial flash command engine
// Functional notes
// - Fast read: opcode, 24-bit address, dummy byte
// - Read data driven on falling clock edges
// - Read address increments, wraps to zero
// - Chip select high ends read output
// - Fast read rejected while cycle busy
// - Unused top address bits ignored per size
// - Opcode AB reads silicon identifier, all sizes but 128 Mbit
// - Silicon id after three dummy bytes
// - Identifier repeats while clocks continue
// - Identifier reads ignored while cycle busy
// - Opcode 9F reads device identification, 128 Mbit only
// - Device id after two dummy bytes
// - Opcode 02 programs, needs write enable
// - Program data wraps within page
// - Only last 256 bytes are programmed
// - Unsent page bytes stay unchanged
// - Select rise off byte boundary aborts
// - Write enable latch cleared by program
// - Select rise starts timed cycle, busy
// - Busy flag sits at status bit 0
// - Program cycle 1.5 ms, 2.5 ms large
package sfc_pkg;

    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_SILICON_ID = 8'hAB;
    localparam logic [7:0] OP_DEVICE_ID = 8'h9F;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;

    // Bit counts at the end of each header field, and the count's saturation value
    localparam logic [5:0] ADDR_LAST_BIT = 6'h1F;
    localparam logic [5:0] DUMMY_LAST_BIT = 6'h27;
    localparam logic [5:0] DID_DUMMY_LAST = 6'h17;
    localparam logic [5:0] BCNT_SAT = 6'h28;

    localparam int STATUS_W = 8;
    localparam int STAT_WIP_BIT = 0;
    localparam int STAT_WEL_BIT = 1;
    localparam logic [7:0] FILL_BYTE = 8'hFF;

    localparam int CLK_PERIOD_NS = 10;
    localparam int PGM_TYP_US = 1500;
    localparam int PGM_MAX_US = 5000;
    localparam int PGM_TYP_BIG_US = 2500;
    localparam int PGM_MAX_BIG_US = 7000;
    localparam int PGM_STD_CYCLES = PGM_TYP_US * 1000 / CLK_PERIOD_NS;
    localparam int PGM_BIG_CYCLES = PGM_TYP_BIG_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_FREAD, CMD_SID, CMD_DID, CMD_PROG, CMD_IGN
    } sfc_cmd_type;

    typedef enum logic {PGM_IDLE, PGM_RUN} sfc_pgm_type;

    function automatic int sfc_addr_bits(input int mbit);
        return (mbit >= 128) ? 24 : (mbit >= 64) ? 23 :
               (mbit >= 16) ? 21 : (mbit >= 4) ? 19 : 17;
    endfunction

    function automatic sfc_cmd_type sfc_decode(input logic [7:0] op,
        input logic busy, input logic wel, input int mbit);
        if (busy)
            return CMD_IGN;
        if (op == OP_FAST_READ)
            return CMD_FREAD;
        if (op == OP_SILICON_ID && mbit != 128)
            return CMD_SID;
        if (op == OP_DEVICE_ID && mbit == 128)
            return CMD_DID;
        if (op == OP_PAGE_PROG && wel)
            return CMD_PROG;
        return CMD_IGN;
    endfunction

endpackage

// [logic/sfc_engine.sv]
// Serial flash command engine: fast read, id reads, page program
`timescale 1ns/1ps
`default_nettype none
module sfc_engine #(
    parameter int MEM_MBIT = 1,
    parameter logic [7:0] SILICON_ID = 8'h5A, // Arbitrary value
    parameter logic [15:0] DEVICE_ID = 16'hC3A6, // Arbitrary value
    parameter int PGM_CYCLES = (MEM_MBIT == 128) ?
        sfc_pkg::PGM_BIG_CYCLES : sfc_pkg::PGM_STD_CYCLES
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Serial link pins
    input wire logic serial_clock_in,
    input wire logic cs_b,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_b,
    // Status side
    input wire logic wel_set,
    input wire logic other_busy,
    output logic [sfc_pkg::STATUS_W-1:0] status_byte
);
    import sfc_pkg::*;

    localparam int AW = sfc_addr_bits(MEM_MBIT);
    localparam int DEPTH = 1 << AW;
    localparam int TW = $clog2(PGM_CYCLES + 1);

    typedef struct packed {
        logic [5:0] bcnt;
        logic [2:0] bib;
        sfc_cmd_type cmd;
        logic [7:0] shin;
        logic [23:0] addr;
        logic [AW-1:0] rd_addr;
        logic rd_req;
        logic [7:0] tx_byte;
        logic txing;
        logic id_lo;
        logic [AW-1:0] pg_base;
        logic [7:0] pg_ptr;
        logic [255:0] pg_mask;
        logic pg_any;
        logic frm_tog;
        logic busy_s1;
        logic busy_s2;
        logic wel_s1;
        logic wel_s2;
        logic ack_s1;
        logic ack_s2;
    } sfc_link_type;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic arm_s1;
        logic arm_s2;
        logic tog_s1;
        logic tog_s2;
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic ack;
        logic [7:0] rd_data;
        sfc_pgm_type state;
        logic done_tog;
        logic [8:0] burn;
        logic [TW-1:0] timer;
        logic wel;
        logic [STATUS_W-1:0] status;
    } sfc_core_type;

    sfc_link_type link_reg, link_next, ls;
    sfc_core_type core_reg, core_next;
    logic frame_on_reg;
    logic data_out_reg;
    logic data_oe_b_reg;
    logic [7:0] pg_buf [256];
    // Array starts erased; programming can only clear bits
    logic [7:0] mem [DEPTH] = '{default: FILL_BYTE};
    logic [7:0] byte_in;
    logic [23:0] addr_in;
    logic byte_done;
    logic buf_we;
    logic prog_armed;
    logic cs_rise;
    logic start;
    logic mem_we;
    logic [AW-1:0] mem_waddr;

    ////////////////////////////////////////////////////////////////
    // Link side, on the master's serial clock

    // Cleared while deselected, so the first edge marks a new frame
    always_ff @(posedge serial_clock_in or posedge cs_b or negedge rst_b) begin
        if (!rst_b)
            frame_on_reg <= 1'b0;
        else if (cs_b)
            frame_on_reg <= 1'b0;
        else
            frame_on_reg <= 1'b1;
    end

    always_comb begin
        ls = link_reg;
        if (!frame_on_reg) begin
            ls.bcnt = '0;
            ls.bib = '0;
            ls.cmd = CMD_NONE;
            ls.txing = 1'b0;
            ls.id_lo = 1'b0;
            ls.pg_any = 1'b0;
            ls.frm_tog = ~link_reg.frm_tog;
        end
        link_next = ls;
        link_next.busy_s1 = core_reg.status[STAT_WIP_BIT];
        link_next.busy_s2 = link_reg.busy_s1;
        link_next.wel_s1 = core_reg.wel;
        link_next.wel_s2 = link_reg.wel_s1;
        link_next.ack_s1 = core_reg.ack;
        link_next.ack_s2 = link_reg.ack_s1;
        byte_in = {ls.shin[6:0], serial_data_in};
        addr_in = {ls.addr[22:0], serial_data_in};
        byte_done = (ls.bib == 3'h7);
        buf_we = 1'b0;
        link_next.shin = byte_in;
        link_next.bib = ls.bib + 3'h1;
        if (ls.bcnt != BCNT_SAT)
            link_next.bcnt = ls.bcnt + 6'h01;
        if (ls.bcnt <= ADDR_LAST_BIT)
            link_next.addr = addr_in;
        unique case (ls.cmd)
            CMD_NONE: begin
                if (byte_done) begin
                    link_next.cmd = sfc_decode(byte_in, ls.busy_s2,
                        ls.wel_s2, MEM_MBIT);
                    // Mask kept across frames so a running burn is not disturbed
                    if (link_next.cmd == CMD_PROG)
                        link_next.pg_mask = '0;
                end
            end
            CMD_FREAD: begin
                if (ls.bcnt == ADDR_LAST_BIT) begin
                    // Prefetch during the dummy byte
                    link_next.rd_addr = addr_in[AW-1:0];
                    link_next.rd_req = ~ls.rd_req;
                end else if (byte_done && ls.bcnt >= DUMMY_LAST_BIT) begin
                    // A late fetch shows as erased data, never a stale word
                    link_next.tx_byte = (ls.ack_s2 == ls.rd_req) ?
                        core_reg.rd_data : FILL_BYTE;
                    link_next.txing = 1'b1;
                    link_next.rd_addr = ls.rd_addr + 1'b1;
                    link_next.rd_req = ~ls.rd_req;
                end
            end
            CMD_SID: begin
                if (byte_done && ls.bcnt >= ADDR_LAST_BIT) begin
                    link_next.tx_byte = SILICON_ID;
                    link_next.txing = 1'b1;
                end
            end
            CMD_DID: begin
                if (byte_done && ls.bcnt >= DID_DUMMY_LAST) begin
                    link_next.tx_byte = ls.id_lo ? DEVICE_ID[7:0] :
                        DEVICE_ID[15:8];
                    link_next.id_lo = ~ls.id_lo;
                    link_next.txing = 1'b1;
                end
            end
            CMD_PROG: begin
                if (ls.bcnt == ADDR_LAST_BIT) begin
                    link_next.pg_base = {addr_in[AW-1:8], 8'h00};
                    link_next.pg_ptr = addr_in[7:0];
                end else if (byte_done && ls.bcnt >= DUMMY_LAST_BIT) begin
                    buf_we = 1'b1;
                    link_next.pg_mask[ls.pg_ptr] = 1'b1;
                    link_next.pg_ptr = ls.pg_ptr + 8'h01;
                    link_next.pg_any = 1'b1;
                end
            end
            CMD_IGN: begin
            end
            default: link_next.cmd = CMD_IGN;
        endcase
    end

    always_ff @(posedge serial_clock_in or negedge rst_b) begin
        if (!rst_b)
            link_reg <= '0;
        else
            link_reg <= link_next;
    end

    // Later bytes overwrite the same slot, so the last 256 win
    always_ff @(posedge serial_clock_in) begin
        if (buf_we)
            pg_buf[ls.pg_ptr] <= byte_in;
    end

    // Held after the frame; the link clock stops, so it stays put
    assign prog_armed = (link_reg.cmd == CMD_PROG) &&
        (link_reg.bib == 3'h0) && link_reg.pg_any;

    // Output bits change on the falling edge
    always_ff @(negedge serial_clock_in or posedge cs_b or negedge rst_b) begin
        if (!rst_b) begin
            data_out_reg <= 1'b0;
            data_oe_b_reg <= 1'b1;
        end else if (cs_b) begin
            data_out_reg <= 1'b0;
            data_oe_b_reg <= 1'b1;
        end else begin
            data_out_reg <= link_reg.tx_byte[3'h7 - link_reg.bib];
            data_oe_b_reg <= ~link_reg.txing;
        end
    end

    assign serial_data_out = data_out_reg;
    assign serial_data_oe_b = data_oe_b_reg;

    ////////////////////////////////////////////////////////////////
    // Core side: array, read fetch, timed program cycle

    always_comb begin
        core_next = core_reg;
        core_next.cs_s1 = cs_b;
        core_next.cs_s2 = core_reg.cs_s1;
        core_next.cs_s3 = core_reg.cs_s2;
        core_next.arm_s1 = prog_armed;
        core_next.arm_s2 = core_reg.arm_s1;
        core_next.tog_s1 = link_reg.frm_tog;
        core_next.tog_s2 = core_reg.tog_s1;
        core_next.req_s1 = link_reg.rd_req;
        core_next.req_s2 = core_reg.req_s1;
        core_next.req_s3 = core_reg.req_s2;
        cs_rise = core_reg.cs_s2 & ~core_reg.cs_s3;
        // Each frame toggle runs at most once; bare select pulses do not
        start = cs_rise && core_reg.arm_s2 &&
            (core_reg.tog_s2 != core_reg.done_tog) &&
            (core_reg.state == PGM_IDLE);
        mem_we = 1'b0;
        mem_waddr = '0;
        if (core_reg.req_s2 != core_reg.req_s3) begin
            core_next.rd_data = mem[link_reg.rd_addr];
            core_next.ack = core_reg.req_s2;
        end
        unique case (core_reg.state)
            PGM_IDLE: begin
                if (wel_set)
                    core_next.wel = 1'b1;
                if (start) begin
                    core_next.state = PGM_RUN;
                    core_next.wel = 1'b0;
                    core_next.timer = TW'(PGM_CYCLES - 1);
                    core_next.burn = '0;
                    core_next.done_tog = core_reg.tog_s2;
                end
            end
            PGM_RUN: begin
                if (!core_reg.burn[8]) begin
                    core_next.burn = core_reg.burn + 9'h001;
                    mem_we = link_reg.pg_mask[core_reg.burn[7:0]];
                end
                mem_waddr = link_reg.pg_base | AW'(core_reg.burn[7:0]);
                if (core_reg.timer == '0)
                    core_next.state = PGM_IDLE;
                else
                    core_next.timer = core_reg.timer - 1'b1;
            end
        endcase
        core_next.status = '0;
        core_next.status[STAT_WIP_BIT] =
            (core_next.state == PGM_RUN) | other_busy;
        core_next.status[STAT_WEL_BIT] = core_next.wel;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_reg <= '0;
            core_reg.cs_s1 <= 1'b1;
            core_reg.cs_s2 <= 1'b1;
            core_reg.cs_s3 <= 1'b1;
        end else begin
            core_reg <= core_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (mem_we)
            mem[mem_waddr] <= mem[mem_waddr] & pg_buf[core_reg.burn[7:0]];
    end

    assign status_byte = core_reg.status;

    ////////////////////////////////////////////////////////////////
    // Checks

    a_start_sets_busy: assert property (@(posedge core_clk) disable iff (!rst_b)
        start |=> status_byte[STAT_WIP_BIT] && !status_byte[STAT_WEL_BIT])
        else $error("program start did not raise busy or clear wel");

    a_start_had_wel: assert property (@(posedge core_clk) disable iff (!rst_b)
        start |-> core_reg.wel)
        else $error("program started without write enable");

    a_unarmed_no_run: assert property (@(posedge core_clk) disable iff (!rst_b)
        (core_reg.state == PGM_IDLE && !core_reg.arm_s2)
        |=> core_reg.state == PGM_IDLE)
        else $error("program ran without an armed frame");

    a_run_length: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(core_reg.state == PGM_RUN)
        |-> core_reg.timer == TW'(PGM_CYCLES - 1))
        else $error("program cycle length wrong");

    a_timer_counts: assert property (@(posedge core_clk) disable iff (!rst_b)
        (core_reg.state == PGM_RUN && core_reg.timer != '0)
        |=> core_reg.timer == $past(core_reg.timer) - 1'b1)
        else $error("program timer skipped a count");

    a_busy_holds: assert property (@(posedge core_clk) disable iff (!rst_b)
        (core_reg.state == PGM_RUN && core_reg.timer != '0)
        |=> status_byte[STAT_WIP_BIT])
        else $error("busy dropped before the cycle ended");

    a_wip_other: assert property (@(posedge core_clk) disable iff (!rst_b)
        other_busy |=> status_byte[STAT_WIP_BIT])
        else $error("busy bit missed another running cycle");

    a_burn_masked: assert property (@(posedge core_clk) disable iff (!rst_b)
        mem_we |-> link_reg.pg_mask[core_reg.burn[7:0]]
        && core_reg.state == PGM_RUN)
        else $error("wrote a page byte that was never sent");

    a_wel_kept_in_run: assert property (@(posedge core_clk) disable iff (!rst_b)
        (core_reg.state == PGM_RUN) |-> !core_reg.wel)
        else $error("write enable latch set during program");

    a_oe_off_desel: assert property (@(posedge core_clk) disable iff (!rst_b)
        cs_b |-> serial_data_oe_b)
        else $error("data line driven while deselected");

    a_busy_rejects: assert property (@(posedge serial_clock_in) disable iff (!rst_b)
        (ls.cmd == CMD_NONE && byte_done && ls.busy_s2)
        |=> link_reg.cmd == CMD_IGN)
        else $error("command accepted while busy");

    a_refused_quiet: assert property (@(posedge serial_clock_in) disable iff (!rst_b)
        link_reg.cmd == CMD_IGN |-> !link_reg.txing)
        else $error("refused command drove the data line");

    a_read_wraps: assert property (@(posedge serial_clock_in) disable iff (!rst_b)
        (ls.cmd == CMD_FREAD && byte_done && ls.bcnt >= DUMMY_LAST_BIT
        && ls.rd_addr == '1) |=> link_reg.rd_addr == '0)
        else $error("read address did not wrap to zero");

    a_page_wraps: assert property (@(posedge serial_clock_in) disable iff (!rst_b)
        (buf_we && ls.pg_ptr == 8'hFF) |=> link_reg.pg_ptr == 8'h00
        && link_reg.pg_base == $past(ls.pg_base))
        else $error("program data left its page");

    a_fresh_frame: assert property (@(posedge serial_clock_in) disable iff (!rst_b)
        !frame_on_reg |=> link_reg.bcnt == 6'h01
        && link_reg.cmd == CMD_NONE)
        else $error("new selection did not restart decoding");

endmodule
`default_nettype wire

// [tb/sfc_master.sv]
// Behavioural serial master that drives the flash link
`timescale 1ns/1ps
`default_nettype none
module sfc_master (
    // Link pins driven by the master
    output var logic serial_clock_in,
    output var logic cs_b,
    output var logic serial_data_in,
    // Link pins driven by the device
    input wire logic serial_data_out,
    input wire logic serial_data_oe_b
);
    logic oe_seen;

    initial begin
        serial_clock_in = 1'b0;
        cs_b = 1'b1;
        serial_data_in = 1'b0;
        oe_seen = 1'b0;
    end

    // Clock stands low between frames
    task automatic sel();
        cs_b = 1'b0;
        oe_seen = 1'b0;
        #23;
    endtask

    // Shifts n bits MSB first, samples the reply on each rise
    task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            serial_data_in = tx[i];
            #15 serial_clock_in = 1'b1;
            rx[i] = serial_data_out;
            if (serial_data_oe_b === 1'b0)
                oe_seen = 1'b1;
            #15 serial_clock_in = 1'b0;
        end
    endtask

    // Raw image bytes go out LSB first
    task automatic raw(input logic [7:0] tx, output logic [7:0] rx);
        logic [7:0] r;
        for (int i = 0; i < 8; i++)
            r[i] = tx[7 - i];
        bits(r, 8, rx);
    endtask

    // Released data line shows the inverse, never a stale level
    task automatic desel();
        #10 cs_b = 1'b1;
        serial_data_in = ~serial_data_in;
        #120;
    endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the serial flash command engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sfc_pkg::*;
    localparam int PGM = 400;
    localparam logic [7:0] SID = 8'h3C; // Arbitrary value
    logic core_clk;
    logic rst_b;
    logic serial_clock_in;
    logic cs_b;
    logic serial_data_in;
    logic serial_data_out;
    logic serial_data_oe_b;
    logic wel_set;
    logic other_busy;
    logic [STATUS_W-1:0] status_byte;
    logic [7:0] rx;
    int mismatches;
    int n_compared;

    sfc_engine #(.MEM_MBIT(1), .SILICON_ID(SID), .PGM_CYCLES(PGM)) sfc_engine_i (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .serial_clock_in(serial_clock_in),
        .cs_b(cs_b),
        .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out),
        .serial_data_oe_b(serial_data_oe_b),
        .wel_set(wel_set),
        .other_busy(other_busy),
        .status_byte(status_byte)
    );

    sfc_master sfc_master_i (
        .serial_clock_in(serial_clock_in),
        .cs_b(cs_b),
        .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out),
        .serial_data_oe_b(serial_data_oe_b)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic xb(input logic [7:0] tx);
        sfc_master_i.bits(tx, 8, rx);
    endtask

    task automatic hdr(input logic [7:0] op, input logic [23:0] a);
        sfc_master_i.sel();
        xb(op);
        for (int i = 2; i >= 0; i--)
            xb(a[i*8 +: 8]);
    endtask

    // Three bytes from a; a partial byte then checks the abort
    task automatic fread(input logic [23:0] a, input logic [23:0] exp);
        hdr(OP_FAST_READ, a);
        xb(8'h00);
        for (int i = 2; i >= 0; i--) begin
            xb(8'h00);
            chk("read byte", rx, exp[i*8 +: 8]);
        end
        sfc_master_i.bits(8'h00, 3, rx);
        sfc_master_i.desel();
        chk("oe_b after abort", serial_data_oe_b, 1'b1);
    endtask

    task automatic set_wel();
        cyc(1);
        wel_set = 1'b1;
        cyc(1);
        wel_set = 1'b0;
        cyc(1);
        chk("wel", status_byte[STAT_WEL_BIT], 1'b1);
    endtask

    task automatic prog_wait();
        int n;
        n = 0;
        cyc(5);
        chk("busy", status_byte[STAT_WIP_BIT], 1'b1);
        chk("wel cleared", status_byte[STAT_WEL_BIT], 1'b0);
        while (status_byte[STAT_WIP_BIT] === 1'b1 && n < 2000) begin
            cyc(1);
            n++;
        end
        chk("cycle length", (n >= PGM - 40 && n <= PGM) ? 1'b1 : 1'b0, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_sid();
        sfc_master_i.sel();
        xb(OP_SILICON_ID);
        repeat (3) xb(8'h00);
        repeat (3) begin
            xb(8'h00);
            chk("silicon id", rx, SID);
        end
        sfc_master_i.desel();
        // Device id read is not offered on the small part
        hdr(OP_DEVICE_ID, 24'h000000);
        repeat (2) xb(8'h00);
        chk("device id refused", sfc_master_i.oe_seen, 1'b0);
        sfc_master_i.desel();
    endtask

    task automatic t_busy();
        cyc(1);
        other_busy = 1'b1;
        cyc(2);
        chk("busy bit", status_byte[STAT_WIP_BIT], 1'b1);
        hdr(OP_FAST_READ, 24'h000000);
        repeat (3) xb(8'h00);
        chk("read refused", sfc_master_i.oe_seen, 1'b0);
        sfc_master_i.desel();
        sfc_master_i.sel();
        repeat (6) xb(OP_SILICON_ID);
        chk("id refused", sfc_master_i.oe_seen, 1'b0);
        sfc_master_i.desel();
        cyc(1);
        other_busy = 1'b0;
        cyc(4);
    endtask

    task automatic t_prog();
        hdr(OP_PAGE_PROG, 24'h000010);
        xb(8'h00);
        sfc_master_i.desel();
        cyc(5);
        chk("no wel no cycle", status_byte[STAT_WIP_BIT], 1'b0);
        set_wel();
        hdr(OP_PAGE_PROG, 24'h000010);
        xb(8'h00);
        sfc_master_i.bits(8'h00, 4, rx);
        sfc_master_i.desel();
        cyc(5);
        chk("ragged end", status_byte[STAT_WIP_BIT], 1'b0);
        chk("wel kept", status_byte[STAT_WEL_BIT], 1'b1);
        // Bit 20 lies beyond the 1 Mbit array
        hdr(OP_PAGE_PROG, 24'h1000FE);
        for (int i = 2; i >= 0; i--)
            xb(8'(24'hA1B2C3 >> (i * 8)));
        sfc_master_i.desel();
        prog_wait();
        fread(24'h00000F, 24'hFFFFFF);
        fread(24'h0000FD, 24'hFFA1B2);
        fread(24'h0000FF, 24'hB2FFFF);
        fread(24'h01FFFF, 24'hFFC3FF);
    endtask

    // Target page is still erased
    task automatic t_long();
        set_wel();
        hdr(OP_PAGE_PROG, 24'h000200);
        for (int i = 0; i < 256; i++)
            xb(i < 2 ? 8'h11 : 8'h3C);
        // Raw image bytes land as shifted, so they read back mirrored
        repeat (2) sfc_master_i.raw(8'h77, rx);
        sfc_master_i.desel();
        prog_wait();
        fread(24'h000200, 24'hEEEE3C);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        wel_set = 1'b0;
        other_busy = 1'b0;
        mismatches = 0;
        n_compared = 0;
        repeat (5) @(posedge core_clk);
        chk("status at reset", status_byte, 8'h00);
        chk("oe_b at reset", serial_data_oe_b, 1'b1);
        #1 rst_b = 1'b1;
        cyc(4);
        t_sid();
        t_busy();
        t_prog();
        t_long();
        test_done();
    end

    initial begin
        #500000;
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire
